// ### core/comparator_map.vh
`ifndef COMPARATOR_MAP_VH
`define COMPARATOR_MAP_VH

// register offsets (8-bit index space)
`define ADDR_CMP_TIMER_A_CTRL 8'h08
`define ADDR_WAKE_IRQ_CTRL 8'h0E
`define ADDR_WAKE_FLAG 8'h0D
`define ADDR_IRQ_MASK 8'h10

// control register fields
`define BIT_COMPARE_RESULT 5
`define BIT_SEL_HI 4
`define BIT_SEL_LO 3
`define CTRL_RESET 8'h00
`define CTRL_WR_MASK 8'h1F

// wake/irq control: enable at bit 4
`define BIT_CMP_IRQ_ENABLE 4
// wake flag register: wake enable bit 2, flag bit 4
`define BIT_CMP_WAKE_ENABLE 2
`define BIT_CMP_IRQ_FLAG 4
// irq mask register shares the status layout: mask bit sits over the flag
`define BIT_IRQ_MASK 4

// select field encodings
`define SEL_PIN 2'h2
`define SEL_OPAMP 2'h3

`define INT_VECTOR 12'h00F

`endif

// ### core/comparator_irq_wake_control.v
`timescale 1ns/1ps
`include "comparator_map.vh"

module comparator_irq_wake_control (
  // clock and reset
  input wire i_mclk,
  input wire i_reset,
  // register port
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // analog comparator
  input wire i_cmp_raw,
  output wire o_cmp_enable,
  output wire o_schmitt_enable,
  // comparator output pin
  output wire o_cmp_output_pin,
  output wire o_cmp_pin_oe_n,
  // core
  input wire i_sleeping,
  input wire i_global_irq_en,
  output wire o_irq,
  output wire o_wake,
  output wire o_resume_next,
  output wire [11:0] o_vector
);

  reg [7:0] ctrl_ff;
  reg irq_enable_ff;
  reg wake_enable_ff;
  reg irq_flag_ff;
  reg irq_mask_ff;
  reg sync1_ff;
  reg sync2_ff;
  reg result_ff;
  reg [1:0] prime_ff;
  reg wake_ff;
  reg resume_ff;
  reg [7:0] nxt_rdata;
  reg [7:0] nxt_ctrl;
  reg nxt_irq_enable;
  reg nxt_wake_enable;
  reg nxt_irq_flag;
  reg nxt_irq_mask;
  reg nxt_result;
  reg [1:0] nxt_prime;
  reg nxt_wake;
  reg nxt_resume;
  reg wr_ctrl;
  reg wr_ie;
  reg wr_flag;
  reg wr_mask;

  // warm-up: no change is reported until the result holds a real sample
  localparam PRIME_SYNC1 = 2'h0;
  localparam PRIME_SYNC2 = 2'h1;
  localparam PRIME_LOAD = 2'h2;
  localparam PRIME_ARMED = 2'h3;

  wire [1:0] sel = {ctrl_ff[`BIT_SEL_HI], ctrl_ff[`BIT_SEL_LO]};
  wire opamp = (sel == `SEL_OPAMP);
  // comparator stops in sleep unless wake is enabled, saving power
  wire cmp_active = ~i_sleeping | wake_enable_ff;
  wire seen = (prime_ff == PRIME_ARMED);
  wire change = seen & cmp_active & (sync2_ff != result_ff);
  wire event_ok = change & ~opamp;
  wire sleep_wake = i_sleeping & wake_enable_ff;
  wire clear_flag = wr_flag & i_wdata[`BIT_CMP_IRQ_FLAG];

  // unmapped indices decode to nothing, so writes there are dropped
  always @* begin
    wr_ctrl = 1'b0;
    wr_ie = 1'b0;
    wr_flag = 1'b0;
    wr_mask = 1'b0;
    if (i_wr) begin
      case (i_addr)
        `ADDR_CMP_TIMER_A_CTRL: wr_ctrl = 1'b1;
        `ADDR_WAKE_IRQ_CTRL: wr_ie = 1'b1;
        `ADDR_WAKE_FLAG: wr_flag = 1'b1;
        `ADDR_IRQ_MASK: wr_mask = 1'b1;
        default: wr_ctrl = 1'b0;
      endcase
    end
  end

  assign o_cmp_enable = cmp_active;
  assign o_schmitt_enable = ~opamp;
  assign o_cmp_output_pin = result_ff;
  // pin released to port logic except in routing mode
  assign o_cmp_pin_oe_n = ~(sel == `SEL_PIN);

  assign o_irq = irq_flag_ff & irq_enable_ff & irq_mask_ff & ~opamp;
  wire take_vec = o_irq & i_global_irq_en;
  assign o_vector = take_vec ? `INT_VECTOR : 12'h000;
  // a pulse launched just before op-amp mode is swallowed
  assign o_wake = wake_ff & ~opamp;
  assign o_resume_next = resume_ff & ~opamp;

  always @(posedge i_mclk) begin
    if (i_reset) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= i_cmp_raw;
      sync2_ff <= sync1_ff;
    end
  end

  always @* begin
    nxt_prime = prime_ff;
    case (prime_ff)
      PRIME_SYNC1: begin
        nxt_prime = PRIME_SYNC2;
      end
      PRIME_SYNC2: begin
        nxt_prime = PRIME_LOAD;
      end
      PRIME_LOAD: begin
        nxt_prime = PRIME_ARMED;
      end
      PRIME_ARMED: begin
        nxt_prime = PRIME_ARMED;
      end
      default: begin
        nxt_prime = PRIME_SYNC1;
      end
    endcase
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      prime_ff <= PRIME_SYNC1;
    end else begin
      prime_ff <= nxt_prime;
    end
  end

  // once armed, result freezes while the comparator is powered down in sleep; during warm-up it still loads sync2_ff
  always @* begin
    nxt_result = result_ff;
    if (cmp_active | ~seen) begin
      nxt_result = sync2_ff;
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      result_ff <= 1'b0;
    end else begin
      result_ff <= nxt_result;
    end
  end

  always @* begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl = i_wdata & `CTRL_WR_MASK;
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      ctrl_ff <= `CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  always @* begin
    nxt_irq_enable = irq_enable_ff;
    if (wr_ie) begin
      nxt_irq_enable = i_wdata[`BIT_CMP_IRQ_ENABLE];
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      irq_enable_ff <= 1'b0;
    end else begin
      irq_enable_ff <= nxt_irq_enable;
    end
  end

  always @* begin
    nxt_irq_mask = irq_mask_ff;
    if (wr_mask) begin
      nxt_irq_mask = i_wdata[`BIT_IRQ_MASK];
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      irq_mask_ff <= 1'b0;
    end else begin
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  always @* begin
    nxt_wake_enable = wake_enable_ff;
    if (wr_flag) begin
      nxt_wake_enable = i_wdata[`BIT_CMP_WAKE_ENABLE];
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      wake_enable_ff <= 1'b0;
    end else begin
      wake_enable_ff <= nxt_wake_enable;
    end
  end

  // set wins over a write-one clear in the same cycle
  always @* begin
    nxt_irq_flag = irq_flag_ff;
    if (event_ok) begin
      nxt_irq_flag = 1'b1;
    end else if (clear_flag) begin
      nxt_irq_flag = 1'b0;
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      irq_flag_ff <= 1'b0;
    end else begin
      irq_flag_ff <= nxt_irq_flag;
    end
  end

  always @* begin
    nxt_wake = 1'b0;
    if (event_ok & sleep_wake) begin
      nxt_wake = 1'b1;
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= nxt_wake;
    end
  end

  // resume only matters to a core that keeps global interrupts off
  always @* begin
    nxt_resume = 1'b0;
    if (event_ok & sleep_wake & irq_enable_ff & ~i_global_irq_en) begin
      nxt_resume = 1'b1;
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      resume_ff <= 1'b0;
    end else begin
      resume_ff <= nxt_resume;
    end
  end

  always @* begin
    nxt_rdata = 8'h00;
    case (i_addr)
      `ADDR_CMP_TIMER_A_CTRL: begin
        nxt_rdata = ctrl_ff;
        nxt_rdata[`BIT_COMPARE_RESULT] = result_ff;
      end
      `ADDR_WAKE_IRQ_CTRL: nxt_rdata[`BIT_CMP_IRQ_ENABLE] = irq_enable_ff;
      `ADDR_WAKE_FLAG: begin
        nxt_rdata[`BIT_CMP_WAKE_ENABLE] = wake_enable_ff;
        nxt_rdata[`BIT_CMP_IRQ_FLAG] = irq_flag_ff;
      end
      `ADDR_IRQ_MASK: nxt_rdata[`BIT_IRQ_MASK] = irq_mask_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= nxt_rdata;
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule

// ### tb/cmp_model.sv
`timescale 1ns/1ps
// comparator output settles a little after the analog inputs cross
module cmp_model(input wire logic i_level, output wire logic o_raw);
  assign #3 o_raw = i_level;
endmodule

// ### tb/cmp_ctrl_chk.sv
`timescale 1ns/1ps
module cmp_ctrl_chk(input wire i_mclk, i_reset, i_wr, i_rd, i_global_irq_en, i_sleeping,
  input wire [7:0] i_addr, i_wdata, o_rdata,
  input wire o_schmitt_enable, o_cmp_pin_oe_n, o_irq, o_wake, o_resume_next,
  input wire [11:0] o_vector);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  wire sel_wr = i_wr && i_addr == 8'h08;
  sequence s_pin_wr; sel_wr && i_wdata[4:3] == 2'h2; endsequence
  sequence s_amp_wr; sel_wr && i_wdata[4:3] == 2'h3; endsequence
  property p_pin; s_pin_wr |=> !o_cmp_pin_oe_n; endproperty
  a_pin: assert property (p_pin) else $error("pin not driven");
  property p_amp; s_amp_wr |=> !o_schmitt_enable && o_cmp_pin_oe_n; endproperty
  a_amp: assert property (p_amp) else $error("amp mode");
  property p_free; sel_wr && i_wdata[4] == 1'b0 |=> o_cmp_pin_oe_n; endproperty
  a_free: assert property (p_free) else $error("pin taken");
  property p_quiet; !o_schmitt_enable |-> !o_irq && !o_wake; endproperty
  a_quiet: assert property (p_quiet) else $error("amp event");
  property p_hold; o_irq && !i_wr |=> o_irq; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped");
  property p_vec; o_vector == ((o_irq && i_global_irq_en) ? 12'h00F : 12'h000); endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_res; o_resume_next |-> o_wake; endproperty
  a_res: assert property (p_res) else $error("resume");
  property p_wake; o_wake |-> $past(i_sleeping); endproperty
  a_wake: assert property (p_wake) else $error("wake while running");
  property p_rd; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("rdata");
endmodule
bind comparator_irq_wake_control cmp_ctrl_chk chk_u (.i_mclk, .i_reset, .i_wr, .i_rd, .i_global_irq_en, .i_sleeping,
  .i_addr, .i_wdata, .o_rdata, .o_schmitt_enable, .o_cmp_pin_oe_n, .o_irq, .o_wake, .o_resume_next, .o_vector);

// ### tb/comparator_irq_wake_control_tb.sv
`timescale 1ns/1ps
module comparator_irq_wake_control_tb;
  logic i_mclk = 0, i_reset = 1, i_wr = 0, i_rd = 0, i_sleeping = 0, i_global_irq_en = 1, lvl = 0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
  wire i_cmp_raw, o_cmp_enable, o_schmitt_enable, o_cmp_output_pin, o_cmp_pin_oe_n, o_irq, o_wake, o_resume_next;
  wire [7:0] o_rdata;
  wire [11:0] o_vector;
  int miscompares = 0, samples_checked = 0;
  always #4 i_mclk = ~i_mclk;
  cmp_model pm_u (.i_level(lvl), .o_raw(i_cmp_raw));
  comparator_irq_wake_control dut_u (.i_mclk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_cmp_raw,
    .o_cmp_enable, .o_schmitt_enable, .o_cmp_output_pin, .o_cmp_pin_oe_n, .i_sleeping, .i_global_irq_en,
    .o_irq, .o_wake, .o_resume_next, .o_vector);
  task chk(input logic [11:0] g, e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge i_mclk);
    i_wr <= 1; i_addr <= a; i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 0;
    @(negedge i_mclk);
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge i_mclk);
    i_rd <= 1; i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 0;
    @(negedge i_mclk);
    chk(o_rdata, e);
  endtask
  task flip;
    lvl = ~lvl;
    repeat (6) @(negedge i_mclk);
  endtask
  task give_verdict;
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task t_regs;
    rd(8'h08, 8'h00);
    chk(o_cmp_pin_oe_n, 1);
    wr(8'h08, 8'h08);
    chk(o_cmp_pin_oe_n, 1);
    chk(o_schmitt_enable, 1);
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'h1F);
    chk(o_schmitt_enable, 0);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    $display("regs done");
  endtask
  task t_opamp;
    wr(8'h0E, 8'h10);
    wr(8'h10, 8'h10);
    flip;
    chk(o_irq, 0);
    rd(8'h0D, 8'h00);
    wr(8'h08, 8'h10);
    wr(8'h0D, 8'h10);
    chk(o_cmp_pin_oe_n, 0);
    chk(o_cmp_output_pin, 1);
    $display("opamp done");
  endtask
  task t_irq;
    flip;
    rd(8'h0D, 8'h10);
    chk(o_vector, 12'h00F);
    chk(o_cmp_output_pin, 0);
    rd(8'h08, 8'h10);
    wr(8'h0D, 8'h00);
    chk(o_irq, 1);
    wr(8'h0E, 8'h00);
    chk(o_irq, 0);
    wr(8'h0D, 8'h10);
    flip;
    rd(8'h0D, 8'h10);
    $display("irq done");
  endtask
  // a lost wake pulse must not hang the run
  task wait_wake(input logic exp_res);
    int n;
    lvl = ~lvl;
    for (n = 0; n < 20 && o_wake !== 1; n++) @(negedge i_mclk);
    chk(n < 20, 1);
    chk(o_resume_next, exp_res);
    if (n == 20) give_verdict;
  endtask
  task t_wake;
    @(posedge i_mclk);
    i_sleeping <= 1;
    i_global_irq_en <= 0;
    wr(8'h0E, 8'h10);
    wr(8'h0D, 8'h14);
    chk(o_cmp_enable, 1);
    wait_wake(1);
    @(posedge i_mclk);
    i_global_irq_en <= 1;
    wr(8'h0D, 8'h14);
    wait_wake(0);
    chk(o_vector, 12'h00F);
    wr(8'h0D, 8'h10);
    chk(o_cmp_enable, 0);
    flip;
    rd(8'h0D, 8'h00);
    $display("wake done");
  endtask
  initial begin
    repeat (3) @(posedge i_mclk);
    i_reset <= 0;
    t_regs;
    t_opamp;
    t_irq;
    t_wake;
    give_verdict;
  end
endmodule
